// ---- verilog/ssc_regs.vh ----
// Constants for the serial clock, wait and shift-edge block.
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_CLK_SEL_W      3
`define SSC_CLK_EXT        3'h7
`define SSC_CLK_SLOW       3'h0
`define SSC_DIV_SLOW_FC    4'hc
`define SSC_DIV_SLOW_FS    4'h4
`define SSC_DIV_BASE       4'h9
`define SSC_BITS           4'h8
`define SSC_MSB            3'h7
`define SSC_LSB            3'h0
`define SSC_CNT_W          12
`endif

// ---- verilog/ssc_rate_div.v ----
// Restartable divider that makes one-cycle enables at twice the serial clock rate.
`timescale 1ns/1ps
module ssc_rate_div #(
    parameter CNT_W = 12
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Rate control
    input  wire             restart_i,
    input  wire [3:0]       div_log2_i,
    input  wire             fs_tick_i,
    input  wire             use_fs_i,
    // Half-period enable
    output reg              half_tick_o
);
    reg  [CNT_W-1:0] cnt_r;
    wire [CNT_W-1:0] last;
    wire             step;

    // A half period is 2^(n-1) source ticks.
    assign last = (({{(CNT_W-1){1'b0}}, 1'b1} << (div_log2_i - 4'h1)) - {{(CNT_W-1){1'b0}}, 1'b1});
    assign step = use_fs_i ? fs_tick_i : 1'b1;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r       <= {CNT_W{1'b0}};
            half_tick_o <= 1'b0;
        end else if (restart_i) begin
            cnt_r       <= {CNT_W{1'b0}};
            half_tick_o <= 1'b0;
        end else if (step) begin
            if (cnt_r >= last) begin
                cnt_r       <= {CNT_W{1'b0}};
                half_tick_o <= 1'b1;
            end else begin
                cnt_r       <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                half_tick_o <= 1'b0;
            end
        end else begin
            half_tick_o <= 1'b0;
        end
    end
endmodule

// ---- verilog/ssc_core.v ----
// Serial clock generation, automatic wait, shift edges and bit order.
// What this block does
// - Codes other than 111 drive internal clock.
// - Internal clock idles high around transfers.
// - Clock stops while buffer access pending.
// - Clock resumes within one serial period.
// - Code 000 and 001-110 select divide ratios.
// - Code 111 takes external clock, pin undriven.
// - Transmit shifts out on falling edge.
// - Receive samples on rising edge.
// - One bit order for both directions.
// - Order 0 is MSB first, 1 LSB first.
`timescale 1ns/1ps
`include "ssc_regs.vh"
module ssc_core #(
    parameter CNT_W = `SSC_CNT_W
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Configuration
    input  wire [2:0] clk_sel_i,
    input  wire       divider_clock_select_i,
    input  wire       slow_mode_i,
    input  wire       low_freq_tick_i,
    input  wire       bit_order_select_i,
    // Transfer control from the mode sequencer
    input  wire       transfer_run_bit_i,
    input  wire       tx_data_ready_i,
    input  wire       rx_buffer_free_i,
    input  wire [7:0] tx_data_i,
    // Serial pins
    input  wire       serial_clock_pin_i,
    output reg        serial_clock_pin_o,
    output reg        serial_clock_pin_oe_n_o,
    input  wire       serial_in_pin_i,
    output reg        serial_out_pin_o,
    // Status and data to the mode sequencer
    output reg        transfer_active_flag_o,
    output reg        byte_load_o,
    output reg        byte_done_o,
    output reg  [7:0] rx_data_o,
    output reg        wait_o
);
    // ****************************************************************
    // Clock selection
    // ****************************************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_LOW  = 3'b010;
    localparam ST_HIGH = 3'b100;

    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [3:0] bit_cnt_r;
    reg  [7:0] tx_sh_r;
    reg  [7:0] rx_sh_r;
    reg        ext_clk_d_r;
    reg  [3:0] div_log2;
    wire       ext_mode;
    wire       use_fs;
    wire       half_tick;
    wire       ready;
    wire       int_fall;
    wire       int_rise;
    wire       ext_fall;
    wire       ext_rise;
    wire       fall;
    wire       rise;

    assign ext_mode = (clk_sel_i == `SSC_CLK_EXT);
    assign use_fs   = (clk_sel_i == `SSC_CLK_SLOW) && (divider_clock_select_i || slow_mode_i);

    always @* begin
        if (clk_sel_i == `SSC_CLK_SLOW) begin
            div_log2 = use_fs ? `SSC_DIV_SLOW_FS : `SSC_DIV_SLOW_FC;
        end else begin
            div_log2 = `SSC_DIV_BASE - {1'b0, clk_sel_i};
        end
    end

    ssc_rate_div #(
        .CNT_W       (CNT_W)
    ) u_div (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .restart_i   (state_r == ST_IDLE),
        .div_log2_i  (div_log2),
        .fs_tick_i   (low_freq_tick_i),
        .use_fs_i    (use_fs),
        .half_tick_o (half_tick)
    );

    // ****************************************************************
    // Internal clock sequencer with automatic wait
    // ****************************************************************
    // A new internal-clock byte may start only when data and room both exist; an external-clock byte needs data only.
    assign ready = tx_data_ready_i && rx_buffer_free_i;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (!ext_mode && transfer_run_bit_i && ready) begin
                    state_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (half_tick) begin
                    if (bit_cnt_r == 4'h0 && !(transfer_run_bit_i && ready)) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_LOW;
                    end
                end
            end
            ST_LOW: begin
                if (half_tick) begin
                    state_nxt = ST_HIGH;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Restarting from idle costs one half period plus one cycle before the first fall.
    assign int_fall = (state_r == ST_HIGH) && (state_nxt == ST_LOW);
    assign int_rise = (state_r == ST_LOW) && half_tick;
    // Pin is taken as synchronous; one delay flop finds its edges.
    assign ext_fall = ext_mode && ext_clk_d_r && !serial_clock_pin_i;
    assign ext_rise = ext_mode && !ext_clk_d_r && serial_clock_pin_i;
    assign fall     = ext_mode ? (ext_fall && (bit_cnt_r != 4'h0 ||
                      (transfer_run_bit_i && tx_data_ready_i))) : int_fall;
    assign rise     = ext_mode ? (ext_rise && transfer_active_flag_o) : int_rise;

    // ****************************************************************
    // Receive shift step
    // ****************************************************************
    // One helper serves both the shifter and the handed-over byte, so they cannot disagree.
    function [7:0] rx_shift;
        input       lsb_first;
        input       in_bit;
        input [7:0] sh;
        begin
            rx_shift = lsb_first ? {in_bit, sh[7:1]} : {sh[6:0], in_bit};
        end
    endfunction

    // ****************************************************************
    // Shift registers and pins
    // ****************************************************************
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r                 <= ST_IDLE;
            bit_cnt_r               <= 4'h0;
            tx_sh_r                 <= 8'h00;
            rx_sh_r                 <= 8'h00;
            ext_clk_d_r             <= 1'b1;
            serial_clock_pin_o      <= 1'b1;
            serial_clock_pin_oe_n_o <= 1'b1;
            serial_out_pin_o        <= 1'b1;
            transfer_active_flag_o  <= 1'b0;
            byte_load_o             <= 1'b0;
            byte_done_o             <= 1'b0;
            rx_data_o               <= 8'h00;
            wait_o                  <= 1'b0;
        end else begin
            state_r                 <= state_nxt;
            ext_clk_d_r             <= serial_clock_pin_i;
            serial_oe_update(ext_mode);
            serial_clock_pin_o      <= ext_mode ? 1'b1 : !(state_nxt == ST_LOW);
            byte_load_o             <= 1'b0;
            byte_done_o             <= 1'b0;
            wait_o                  <= !ext_mode && transfer_active_flag_o && bit_cnt_r == 4'h0 &&
                                       transfer_run_bit_i && !ready;
            if (fall) begin
                if (bit_cnt_r == 4'h0) begin
                    // Leading edge of a byte loads the shifter and puts out its first bit.
                    byte_load_o            <= 1'b1;
                    transfer_active_flag_o <= 1'b1;
                    bit_cnt_r              <= `SSC_BITS;
                    tx_sh_r                <= tx_data_i;
                    serial_out_pin_o       <= bit_order_select_i ? tx_data_i[`SSC_LSB] : tx_data_i[`SSC_MSB];
                end else begin
                    tx_sh_r          <= bit_order_select_i ? {1'b1, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b1};
                    serial_out_pin_o <= bit_order_select_i ? tx_sh_r[1] : tx_sh_r[6];
                end
            end
            if (rise && bit_cnt_r != 4'h0) begin
                // Same order bit steers receive, so both directions always match.
                rx_sh_r   <= rx_shift(bit_order_select_i, serial_in_pin_i, rx_sh_r);
                bit_cnt_r <= bit_cnt_r - 4'h1;
                if (bit_cnt_r == 4'h1) begin
                    byte_done_o <= 1'b1;
                    rx_data_o   <= rx_shift(bit_order_select_i, serial_in_pin_i, rx_sh_r);
                    if (!transfer_run_bit_i) begin
                        transfer_active_flag_o <= 1'b0;
                        // With the internal clock the data line must not move on a rising edge;
                        // the idle branch below parks it high once the sequencer is idle.
                        if (ext_mode) begin
                            serial_out_pin_o   <= 1'b1;
                        end
                    end
                end
            end
            if (state_r == ST_IDLE && !ext_mode && bit_cnt_r == 4'h0 && !transfer_run_bit_i) begin
                transfer_active_flag_o <= 1'b0;
                serial_out_pin_o       <= 1'b1;
            end
        end
    end

    // Pin is released in external mode and driven (enable low) otherwise.
    task serial_oe_update;
        input ext;
        begin
            serial_clock_pin_oe_n_o <= ext;
        end
    endtask
endmodule

// ---- test/ssc_core_assertions.sv ----
// Port assertions for the serial clock block.
`timescale 1ns/1ps
module ssc_core_assertions (
    input wire       clk_i,
    input wire       rst_i,
    input wire [2:0] clk_sel_i,
    input wire       transfer_run_bit_i,
    input wire       serial_clock_pin_o,
    input wire       serial_clock_pin_oe_n_o,
    input wire       serial_out_pin_o,
    input wire       transfer_active_flag_o,
    input wire       byte_done_o,
    input wire [7:0] rx_data_o,
    input wire       wait_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ext; $stable(clk_sel_i) && clk_sel_i == 3'h7 |=> serial_clock_pin_oe_n_o; endproperty
    a_ext: assert property (p_ext) else $error("clock pin driven in external mode");
    property p_int; $stable(clk_sel_i) && clk_sel_i != 3'h7 |=> !serial_clock_pin_oe_n_o; endproperty
    a_int: assert property (p_int) else $error("clock pin not driven");
    property p_end; $fell(transfer_active_flag_o) && clk_sel_i != 3'h7 |-> serial_clock_pin_o [*4]; endproperty
    a_end: assert property (p_end) else $error("clock not high after transfer");
    property p_wait; wait_o |-> serial_clock_pin_o; endproperty
    a_wait: assert property (p_wait) else $error("clock runs during wait");
    property p_resume;
        $fell(wait_o) && transfer_run_bit_i && clk_sel_i == 3'h6 |-> ##[0:8] $fell(serial_clock_pin_o);
    endproperty
    a_resume: assert property (p_resume) else $error("clock late after wait");
    property p_rise; $rose(serial_clock_pin_o) |-> $stable(serial_out_pin_o); endproperty
    a_rise: assert property (p_rise) else $error("output moved on rising edge");
    property p_rx; !byte_done_o |-> $stable(rx_data_o); endproperty
    a_rx: assert property (p_rx) else $error("receive byte moved");
    property p_half6;
        $fell(serial_clock_pin_o) && clk_sel_i == 3'h6 |-> (!serial_clock_pin_o) [*4] ##1 serial_clock_pin_o;
    endproperty
    a_half6: assert property (p_half6) else $error("wrong low phase at code 6");
    property p_half5;
        $fell(serial_clock_pin_o) && clk_sel_i == 3'h5 |-> (!serial_clock_pin_o) [*8] ##1 serial_clock_pin_o;
    endproperty
    a_half5: assert property (p_half5) else $error("wrong low phase at code 5");
endmodule
bind ssc_core ssc_core_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .clk_sel_i(clk_sel_i),
    .transfer_run_bit_i(transfer_run_bit_i), .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o), .serial_out_pin_o(serial_out_pin_o),
    .transfer_active_flag_o(transfer_active_flag_o), .byte_done_o(byte_done_o),
    .rx_data_o(rx_data_o), .wait_o(wait_o));

// ---- test/ssc_peer.sv ----
// External serial device: MSB-first shifter on the clock wire.
`timescale 1ns/1ps
module ssc_peer (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       sck_i,
    input  wire       so_i,
    input  wire [7:0] tx_i,
    output wire       si_o,
    output reg  [7:0] rx_o
);
    reg [2:0] cnt_r;
    reg [2:0] idx_r;
    reg       hold_r;
    reg       tog_r;
    wire      live;
    // Outside a frame the line wanders so a stale bit can never pass.
    // The last bit is kept one extra cycle so a sampler a clock after the rise still sees it.
    assign live = !sck_i || (cnt_r != 3'h0) || hold_r;
    assign si_o = live ? tx_i[idx_r] : tog_r;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_r <= 1'b0;
            tog_r <= 1'b0;
        end else begin
            hold_r <= !sck_i || (cnt_r != 3'h0);
            tog_r <= ~tog_r;
        end
    end
    always @(negedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            idx_r <= 3'h7;
        end else begin
            idx_r <= ~cnt_r;
        end
    end
    always @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 3'h0;
            rx_o <= 8'h00;
        end else begin
            rx_o <= {rx_o[6:0], so_i};
            cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the serial clock block.
`timescale 1ns/1ps
module tb_top;
    reg        clk_i = 1'b0;
    reg        rst_i = 1'b1;
    reg  [2:0] sel = 3'h6;
    reg        dcs = 0, slow = 0, tick = 0, lsb = 0, run = 0, txr = 0, rxf = 0, ext = 1;
    reg  [7:0] txd = 8'h00, pd = 8'h00;
    wire       sck_o, oe_n, so, si, act, ld, done, wt;
    wire [7:0] rxd, prx;
    wire       sck = oe_n ? ext : sck_o;
    integer    mismatches = 0, checked = 0, cyc = 0, i;
    always #5 clk_i = ~clk_i;
    always @(negedge clk_i) tick <= ~tick;
    ssc_core DUT (.clk_i(clk_i), .rst_i(rst_i), .clk_sel_i(sel), .divider_clock_select_i(dcs),
        .slow_mode_i(slow), .low_freq_tick_i(tick), .bit_order_select_i(lsb), .transfer_run_bit_i(run),
        .tx_data_ready_i(txr), .rx_buffer_free_i(rxf), .tx_data_i(txd), .serial_clock_pin_i(sck),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n_o(oe_n), .serial_in_pin_i(si),
        .serial_out_pin_o(so), .transfer_active_flag_o(act), .byte_load_o(ld), .byte_done_o(done),
        .rx_data_o(rxd), .wait_o(wt));
    ssc_peer u_peer (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .so_i(so), .tx_i(pd), .si_o(si), .rx_o(prx));
    function [7:0] rev8(input [7:0] v);
        integer k;
        for (k = 0; k < 8; k = k + 1) rev8[k] = v[7 - k];
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // The run needs about 40000 cycles; the slowest byte dominates.
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 80000) begin
            mismatches = mismatches + 1;
            conclude;
        end
    end
    task xfer(input [2:0] code, input [1:0] d, input o, input hold);
        integer n;
        begin
            sel = code;
            {slow, dcs} = d;
            lsb = o;
            txd = $urandom;
            pd = $urandom;
            run = 1;
            txr = 1;
            rxf = 1;
            if (code == 3'h7) begin
                for (n = 0; n < 8; n = n + 1) begin
                    ext = 0;
                    repeat (4) @(negedge clk_i);
                    run = 0;
                    chk({7'h0, oe_n}, 8'h1);
                    ext = 1;
                    if (n < 7) repeat (4) @(negedge clk_i);
                end
            end else begin
                n = 0;
                while (ld !== 1'b1 && n < 5000) begin @(negedge clk_i); n = n + 1; end
                if (hold) begin
                    n = 0;
                    while (done !== 1'b1 && n < 5000) begin @(negedge clk_i); n = n + 1; end
                    // Leave the received byte unfetched so the clock must park high mid-run.
                    rxf = 0;
                    repeat (20) @(negedge clk_i);
                    chk({6'h0, wt, sck}, 8'h3);
                    rxf = 1;
                    n = 0;
                    while (ld !== 1'b1 && n < 5000) begin @(negedge clk_i); n = n + 1; end
                end
                if (n >= 5000) mismatches = mismatches + 1;
                run = 0;
                chk({7'h0, oe_n}, 8'h0);
            end
            n = 0;
            while (done !== 1'b1 && n < 40000) begin @(negedge clk_i); n = n + 1; end
            if (n >= 40000) mismatches = mismatches + 1;
            chk(rxd, o ? rev8(pd) : pd);
            n = 0;
            while (act !== 1'b0 && n < 5000) begin @(negedge clk_i); n = n + 1; end
            if (n >= 5000) mismatches = mismatches + 1;
            repeat (4) @(negedge clk_i);
            chk(prx, o ? rev8(txd) : txd);
            chk({7'h0, sck}, 8'h1);
        end
    endtask
    initial begin
        i = $urandom(32'h3419cf77);
        repeat (3) @(negedge clk_i);
        rst_i = 0;
        xfer(3'h6, 2'h0, 1'b0, 1'b1);
        for (i = 1; i < 7; i = i + 1) xfer(i[2:0], 2'h0, i[0], 1'b0);
        xfer(3'h0, 2'h1, 1'b0, 1'b0);
        xfer(3'h0, 2'h2, 1'b1, 1'b0);
        xfer(3'h0, 2'h0, 1'b1, 1'b0);
        xfer(3'h7, 2'h0, 1'b0, 1'b0);
        xfer(3'h7, 2'h0, 1'b1, 1'b0);
        conclude;
    end
endmodule
